// >>> hdl/pmcr_pkg.sv
package pmcr_pkg;

  // register byte addresses
  localparam logic [11:0] UVD_CTRL_ADDR = 12'h000;
  localparam logic [11:0] LPM_CTRL_ADDR = 12'h004;

  // first register bit positions
  localparam int UVD_FLAG_BIT = 7;
  localparam int UVD_ACK_BIT = 6;
  localparam int UVD_IRQ_EN_BIT = 5;
  localparam int UVD_RST_EN_BIT = 4;
  localparam int UVD_STOP_EN_BIT = 3;
  localparam int UVD_MASTER_BIT = 2;
  localparam int REF_BUF_BIT = 0;

  // second register bit positions
  localparam int LP_REQ_BIT = 7;
  localparam int LP_STAT_BIT = 6;
  localparam int WAKE_IRQ_BIT = 5;
  localparam int DS_FLAG_BIT = 3;
  localparam int DS_ACK_BIT = 2;
  localparam int DS_PERMIT_BIT = 1;
  localparam int DS_SEL_BIT = 0;

  // apb error answer for unmapped address
  localparam logic PSLVERR_UNMAPPED = 1'b1;

  // analog-side inputs
  typedef struct packed {
    logic undervolt_detect;
    logic regulator_standby;
    logic in_low_power;
    logic in_stop;
    logic irq_active;
    logic deep_stop_wake;
  } pmcr_analog_in_t;

  // control outputs
  typedef struct packed {
    logic undervolt_irq;
    logic undervolt_reset_req;
    logic undervolt_detect_on;
    logic reference_buffer_enable;
    logic regulator_standby_request;
    logic deep_stop_select;
  } pmcr_ctrl_out_t;

endpackage

// >>> hdl/pmcr_once_bit.sv
`timescale 1ns/1ps
`default_nettype none
// write-once bit: first write after reset is kept
module pmcr_once_bit (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // write
  input wire logic wr_i,
  input wire logic wdata_i,
  // state
  output logic value_o,
  output logic locked_o
);

  logic value_ff;
  logic locked_ff;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      value_ff <= 1'b0;
      locked_ff <= 1'b0;
    end else if (wr_i && !locked_ff) begin
      value_ff <= wdata_i;
      locked_ff <= 1'b1;
    end
  end

  assign value_o = value_ff;
  assign locked_o = locked_ff;

endmodule
`default_nettype wire

// >>> hdl/pmcr_regs.sv
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pmcr_regs (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // analog side
  input wire pmcr_pkg::pmcr_analog_in_t ana_i,
  output pmcr_pkg::pmcr_ctrl_out_t ctrl_o
);

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic uv_flag_ff;
  logic uv_irq_en_ff;
  logic uv_stop_en_ff;
  logic ref_buf_ff;
  logic lp_req_ff;
  logic wake_irq_ff;
  logic ds_flag_ff;
  logic ds_sel_ff;
  logic [7:0] nxt_uvd_rd;
  logic [7:0] nxt_lpm_rd;

  wire setup = psel_i && !penable_i;
  wire access = psel_i && penable_i;
  wire hit_uvd = paddr_i == pmcr_pkg::UVD_CTRL_ADDR;
  wire hit_lpm = paddr_i == pmcr_pkg::LPM_CTRL_ADDR;
  wire mapped = hit_uvd || hit_lpm;
  wire wr_uvd = access && pwrite_i && hit_uvd;
  wire wr_lpm = access && pwrite_i && hit_lpm;

  ////////////////////////////////////////////////////////////////////////
  // write-once bits

  logic uv_master;
  logic uv_rst_en;
  logic ds_permit;

  pmcr_once_bit u_master (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .wr_i(wr_uvd),
    .wdata_i(pwdata_i[pmcr_pkg::UVD_MASTER_BIT]),
    .value_o(uv_master),
    .locked_o()
  );

  pmcr_once_bit u_rst_en (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .wr_i(wr_uvd),
    .wdata_i(pwdata_i[pmcr_pkg::UVD_RST_EN_BIT]),
    .value_o(uv_rst_en),
    .locked_o()
  );

  pmcr_once_bit u_permit (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .wr_i(wr_lpm),
    .wdata_i(pwdata_i[pmcr_pkg::DS_PERMIT_BIT]),
    .value_o(ds_permit),
    .locked_o()
  );

  ////////////////////////////////////////////////////////////////////////
  // undervolt detect

  // detection live when enabled and not stopped or stop-enabled
  wire uv_active = uv_master && (!ana_i.in_stop || uv_stop_en_ff);
  wire uv_event = uv_active && ana_i.undervolt_detect;
  wire uv_ack = wr_uvd && pwdata_i[pmcr_pkg::UVD_ACK_BIT];
  // set wins over clear
  wire nxt_uv_flag = uv_event || (uv_flag_ff && !uv_ack);

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      uv_flag_ff <= 1'b0;
      uv_irq_en_ff <= 1'b0;
      uv_stop_en_ff <= 1'b0;
      ref_buf_ff <= 1'b0;
    end else begin
      uv_flag_ff <= nxt_uv_flag;
      if (wr_uvd) begin
        uv_irq_en_ff <= pwdata_i[pmcr_pkg::UVD_IRQ_EN_BIT];
        uv_stop_en_ff <= pwdata_i[pmcr_pkg::UVD_STOP_EN_BIT];
        ref_buf_ff <= pwdata_i[pmcr_pkg::REF_BUF_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // low power mode

  wire wr_req = pwdata_i[pmcr_pkg::LP_REQ_BIT];
  wire wr_sel = pwdata_i[pmcr_pkg::DS_SEL_BIT];
  // select needs permit and no standing request
  wire sel_ok = ds_permit && !lp_req_ff;
  wire nxt_ds_sel = wr_lpm ? (wr_sel && sel_ok) : (ds_sel_ff && ds_permit);
  // request refused when select set or set in same write
  wire req_blocked = ds_sel_ff || (wr_sel && sel_ok);
  wire wake_clr = ana_i.in_low_power && ana_i.irq_active && wake_irq_ff;
  wire nxt_lp_req = wake_clr ? 1'b0 : (wr_lpm ? (wr_req && !req_blocked) : lp_req_ff);
  wire ds_ack = wr_lpm && pwdata_i[pmcr_pkg::DS_ACK_BIT];
  wire nxt_ds_flag = ana_i.deep_stop_wake || (ds_flag_ff && !ds_ack);

  // no deep-stop-exit reset term: contents persist
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lp_req_ff <= 1'b0;
      wake_irq_ff <= 1'b0;
      ds_flag_ff <= 1'b0;
      ds_sel_ff <= 1'b0;
    end else begin
      lp_req_ff <= nxt_lp_req;
      ds_sel_ff <= nxt_ds_sel;
      ds_flag_ff <= nxt_ds_flag;
      if (wr_lpm) begin
        wake_irq_ff <= pwdata_i[pmcr_pkg::WAKE_IRQ_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read back

  always_comb begin
    nxt_uvd_rd = 8'h00; // ack and reserved read zero
    nxt_uvd_rd[pmcr_pkg::UVD_FLAG_BIT] = uv_flag_ff;
    nxt_uvd_rd[pmcr_pkg::UVD_IRQ_EN_BIT] = uv_irq_en_ff;
    nxt_uvd_rd[pmcr_pkg::UVD_RST_EN_BIT] = uv_rst_en;
    nxt_uvd_rd[pmcr_pkg::UVD_STOP_EN_BIT] = uv_stop_en_ff;
    nxt_uvd_rd[pmcr_pkg::UVD_MASTER_BIT] = uv_master;
    nxt_uvd_rd[pmcr_pkg::REF_BUF_BIT] = ref_buf_ff;
    nxt_lpm_rd = 8'h00; // reserved bit four reads zero
    nxt_lpm_rd[pmcr_pkg::LP_REQ_BIT] = lp_req_ff;
    nxt_lpm_rd[pmcr_pkg::LP_STAT_BIT] = ana_i.regulator_standby;
    nxt_lpm_rd[pmcr_pkg::WAKE_IRQ_BIT] = wake_irq_ff;
    nxt_lpm_rd[pmcr_pkg::DS_FLAG_BIT] = ds_flag_ff;
    nxt_lpm_rd[pmcr_pkg::DS_PERMIT_BIT] = ds_permit;
    nxt_lpm_rd[pmcr_pkg::DS_SEL_BIT] = ds_sel_ff;
  end

  // read data and error captured in setup, held through access
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff <= {24'h00_0000, hit_uvd ? nxt_uvd_rd : (hit_lpm ? nxt_lpm_rd : 8'h00)};
      pslverr_ff <= mapped ? 1'b0 : pmcr_pkg::PSLVERR_UNMAPPED;
    end
  end

  assign prdata_o = prdata_ff;
  assign pready_o = 1'b1;
  assign pslverr_o = access && pslverr_ff;

  ////////////////////////////////////////////////////////////////////////
  // control outputs

  assign ctrl_o.undervolt_irq = uv_irq_en_ff && uv_flag_ff;
  assign ctrl_o.undervolt_reset_req = uv_master && uv_rst_en && uv_flag_ff;
  assign ctrl_o.undervolt_detect_on = uv_active;
  assign ctrl_o.reference_buffer_enable = ref_buf_ff;
  assign ctrl_o.regulator_standby_request = lp_req_ff;
  assign ctrl_o.deep_stop_select = ds_sel_ff;

endmodule
`default_nettype wire

// >>> dv/pmcr_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pmcr_chk (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  // analog side
  input wire pmcr_pkg::pmcr_analog_in_t ana_i,
  input wire pmcr_pkg::pmcr_ctrl_out_t ctrl_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  wire acc = psel_i & penable_i;
  wire wr0 = acc & pwrite_i & (paddr_i == 12'h000);
  wire hit = (paddr_i == 12'h000) | (paddr_i == 12'h004);
  sequence s_wr_lp;
    acc && pwrite_i && paddr_i == 12'h004;
  endsequence
  ////////////////////////////////////////
  a_err_unmapped: assert property (acc && !hit |-> pslverr_o && (pwrite_i || prdata_o == 32'h0))
    else $error("unmapped access not refused");
  a_ack_reads_zero: assert property (acc && !pwrite_i |-> prdata_o[31:8] == 24'h0 &&
    (paddr_i != 12'h000 || !prdata_o[6])) else $error("ack bit reads one");
  a_req_refused: assert property (s_wr_lp ##0 (pwdata_i[7] && ctrl_o.deep_stop_select)
    |=> !ctrl_o.regulator_standby_request) else $error("request set beside select");
  a_never_both: assert property (!(ctrl_o.regulator_standby_request &&
    ctrl_o.deep_stop_select)) else $error("request and select both set");
  a_irq_holds: assert property (ctrl_o.undervolt_irq && !wr0 |=> ctrl_o.undervolt_irq)
    else $error("interrupt dropped");
  a_rst_holds: assert property (ctrl_o.undervolt_reset_req && !(wr0 && pwdata_i[6])
    |=> ctrl_o.undervolt_reset_req) else $error("reset request dropped");
  a_buf_write: assert property (wr0 |=> ctrl_o.reference_buffer_enable == $past(pwdata_i[0]))
    else $error("buffer enable wrong");
  a_wake_keeps: assert property (ana_i.deep_stop_wake && !acc |=>
    $stable(ctrl_o.deep_stop_select) && $stable(ctrl_o.reference_buffer_enable))
    else $error("state lost on deep stop exit");
  a_detect_gated: assert property (ctrl_o.undervolt_reset_req && !ana_i.in_stop
    |-> ctrl_o.undervolt_detect_on) else $error("detect off while armed");
endmodule
bind pmcr_regs pmcr_chk chk_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pslverr_o(pslverr_o), .ana_i(ana_i), .ctrl_o(ctrl_o));
`default_nettype wire

// >>> dv/pmcr_ana_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmcr_ana_model (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // scenario knobs
  input wire logic low_supply_i,
  input wire logic low_power_i,
  input wire logic stop_i,
  input wire logic irq_i,
  input wire logic wake_i,
  // device side
  input wire pmcr_pkg::pmcr_ctrl_out_t ctrl_i,
  output pmcr_pkg::pmcr_analog_in_t ana_o
);
  logic stby_ff;
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) stby_ff <= 1'h0;
    else stby_ff <= ctrl_i.regulator_standby_request & low_power_i;
  end
  assign ana_o = '{low_supply_i & ctrl_i.undervolt_detect_on, stby_ff, low_power_i, stop_i,
    irq_i, wake_i};
endmodule
`default_nettype wire

// >>> dv/power_mode_control_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module power_mode_control_regs_bench;
  logic clk_sys_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, err, pslverr;
  logic low = 1'h0, lp = 1'h0, stp = 1'h0, irq = 1'h0, wake = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  pmcr_pkg::pmcr_analog_in_t ana;
  pmcr_pkg::pmcr_ctrl_out_t ctrl;
  int n_fail = 0, check_count = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  pmcr_regs dut_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .ana_i(ana), .ctrl_o(ctrl));
  pmcr_ana_model ana_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .low_supply_i(low),
    .low_power_i(lp), .stop_i(stp), .irq_i(irq), .wake_i(wake), .ctrl_i(ctrl), .ana_o(ana));
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge clk_sys_i);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys_i);
    penable <= 1'h1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk_sys_i);
      if (pready === 1'h1) break;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n == 16) begin
      n_fail++;
      close_out();
    end
  endtask
  task automatic wc(input logic w, input logic [11:0] a, input logic [7:0] d,
    input logic [7:0] e, input string nm);
    if (w) xfer(a, 1'h1, d);
    xfer(a, 1'h0, 8'h00);
    chk(nm, q, {24'h0, e});
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_sys_i);
    sys_rst_i <= 1'h0;
    wc(1'h0, 12'h000, 8'h00, 8'h00, "uvd_rst");
    wc(1'h0, 12'h004, 8'h00, 8'h00, "lpm_rst");
    wc(1'h1, 12'h000, 8'h3d, 8'h3d, "uvd_first");
    wc(1'h1, 12'h000, 8'h00, 8'h14, "uvd_once");
    chk("buf_off", 32'(ctrl.reference_buffer_enable), 32'h0);
    wc(1'h1, 12'h000, 8'h21, 8'h35, "uvd_irq_en");
    stp <= 1'h1;
    low <= 1'h1;
    repeat (3) @(posedge clk_sys_i);
    wc(1'h0, 12'h000, 8'h00, 8'h35, "uvd_in_stop");
    stp <= 1'h0;
    repeat (3) @(posedge clk_sys_i);
    low <= 1'h0;
    wc(1'h0, 12'h000, 8'h00, 8'hb5, "uvd_event");
    chk("irq_rst", 32'({ctrl.undervolt_irq, ctrl.undervolt_reset_req}), 32'h3);
    wc(1'h1, 12'h000, 8'h61, 8'h35, "uvd_ack");
    wc(1'h1, 12'h000, 8'h29, 8'h3d, "uvd_stop_en");
    stp <= 1'h1;
    low <= 1'h1;
    repeat (3) @(posedge clk_sys_i);
    wc(1'h0, 12'h000, 8'h00, 8'hbd, "uvd_stop_evt");
    stp <= 1'h0;
    low <= 1'h0;
    wc(1'h1, 12'h000, 8'h61, 8'h35, "uvd_ack_again");
    wc(1'h1, 12'h004, 8'h02, 8'h02, "lpm_permit");
    wc(1'h1, 12'h004, 8'h83, 8'h03, "lpm_both");
    wc(1'h1, 12'h004, 8'h81, 8'h03, "lpm_refused");
    wc(1'h1, 12'h004, 8'h00, 8'h02, "lpm_sel_clr");
    wc(1'h1, 12'h004, 8'h80, 8'h82, "lpm_req");
    lp <= 1'h1;
    repeat (3) @(posedge clk_sys_i);
    wc(1'h1, 12'h004, 8'ha0, 8'he2, "lpm_stby");
    irq <= 1'h1;
    @(posedge clk_sys_i);
    irq <= 1'h0;
    repeat (3) @(posedge clk_sys_i);
    wc(1'h0, 12'h004, 8'h00, 8'h22, "lpm_wake");
    lp <= 1'h0;
    wake <= 1'h1;
    @(posedge clk_sys_i);
    wake <= 1'h0;
    wc(1'h0, 12'h004, 8'h00, 8'h2a, "ds_flag");
    chk("buf_kept", 32'(ctrl.reference_buffer_enable), 32'h1);
    wc(1'h1, 12'h004, 8'h24, 8'h22, "ds_ack");
    xfer(12'h008, 1'h0, 8'h00);
    chk("unmapped", {err, q[30:0]}, 32'h80000000);
    sys_rst_i <= 1'h1;
    @(posedge clk_sys_i);
    sys_rst_i <= 1'h0;
    wc(1'h1, 12'h004, 8'h00, 8'h00, "ds_lock");
    wc(1'h1, 12'h004, 8'h03, 8'h00, "ds_locked");
    close_out();
  end
endmodule
`default_nettype wire
